// >>> logic/amp_cfg_pkg.sv
package amp_cfg_pkg;
  localparam logic [6:0] ADDR_LOW_POWER = 7'h35;
  localparam logic [6:0] ADDR_SAMPLE_RATE = 7'h36;
  localparam logic [6:0] ADDR_CLK_POLICY = 7'h4F;
  localparam logic [6:0] ADDR_CLK_TIMING = 7'h50;
  localparam logic [6:0] ADDR_PROT_CFG = 7'h58;
  localparam logic [6:0] ADDR_CHECKSUM = 7'h7E;
  localparam logic [7:0] RST_LOW_POWER = 8'h00;
  localparam logic [7:0] RST_SAMPLE_RATE = 8'h32;
  localparam logic [7:0] RST_CLK_POLICY = 8'h00;
  localparam logic [7:0] RST_CLK_TIMING = 8'h11;
  localparam logic [7:0] RST_PROT_CFG = 8'h03;
  localparam logic [7:0] RST_CHECKSUM = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam int POS_POR_OFF = 7;
  localparam int POS_RATE_LO = 0;
  localparam int POS_CLK2_POLICY = 3;
  localparam int POS_CLK1_POLICY = 2;
  localparam int POS_RAMP_LO = 6;
  localparam int POS_TO1_LO = 3;
  localparam int POS_TO2_LO = 0;
  localparam int POS_OT_RETRY_OFF = 2;
  // clock period in ps and ramp times in us, converted to whole cycles
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RAMP_15_US = 15;
  localparam int RAMP_30_US = 30;
  localparam int RAMP_60_US = 60;
  localparam int RAMP_15_CYC = RAMP_15_US * 1000000 / CLK_PERIOD_PS;
  localparam int RAMP_30_CYC = RAMP_30_US * 1000000 / CLK_PERIOD_PS;
  localparam int RAMP_60_CYC = RAMP_60_US * 1000000 / CLK_PERIOD_PS;
  // timeouts in ns as printed, longest time rounds down
  localparam int TO0_NS = 10600;
  localparam int TO1_NS = 21300;
  localparam int TO2_NS = 42600;
  localparam int TO3_NS = 85300;
  localparam int TO4_NS = 340000;
  localparam int TO5_NS = 680000;
  localparam int TO6_NS = 1360000;
  localparam int TO7_NS = 2730000;
  localparam int TO0_CYC = TO0_NS * 1000 / CLK_PERIOD_PS;
  localparam int TO1_CYC = TO1_NS * 1000 / CLK_PERIOD_PS;
  localparam int TO2_CYC = TO2_NS * 1000 / CLK_PERIOD_PS;
  localparam int TO3_CYC = TO3_NS * 1000 / CLK_PERIOD_PS;
  localparam int TO4_CYC = TO4_NS / 5;
  localparam int TO5_CYC = TO5_NS / 5;
  localparam int TO6_CYC = TO6_NS / 5;
  localparam int TO7_CYC = TO7_NS / 5;
  typedef enum logic [1:0] {
    RATE_8K = 2'b00,
    RATE_16K = 2'b01,
    RATE_48K = 2'b10,
    RATE_96K = 2'b11
  } sample_rate_t;
endpackage : amp_cfg_pkg

// >>> logic/clkfault_if.sv
`timescale 1ns/1ps
// one detector's settings and state between top and watchdog
interface clkfault_if;
  logic [2:0] timeout_code;
  logic shutdown_policy;
  logic clock_seen;
  logic host_recover;
  logic mute;
  logic latched;
  modport ctrl (output timeout_code, shutdown_policy, clock_seen,
    host_recover, input mute, latched);
  modport det (input timeout_code, shutdown_policy, clock_seen,
    host_recover, output mute, latched);
endinterface : clkfault_if

// >>> logic/clkfault_watchdog.sv
`timescale 1ns/1ps
// mutes playback when the watched clock is missing longer than the timeout
module clkfault_watchdog #(
  parameter int TO4_CYC = amp_cfg_pkg::TO4_CYC,
  parameter int TO5_CYC = amp_cfg_pkg::TO5_CYC,
  parameter int TO6_CYC = amp_cfg_pkg::TO6_CYC,
  parameter int TO7_CYC = amp_cfg_pkg::TO7_CYC
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // detector link
  clkfault_if.det port
);
  logic [19:0] idle_q;
  logic [19:0] limit;
  logic mute_q;
  logic latched_q;

  // timeout table, codes above 3 use the long shortenable counts
  always_comb begin
    case (port.timeout_code)
      3'h0: limit = 20'(amp_cfg_pkg::TO0_CYC);
      3'h1: limit = 20'(amp_cfg_pkg::TO1_CYC);
      3'h2: limit = 20'(amp_cfg_pkg::TO2_CYC);
      3'h3: limit = 20'(amp_cfg_pkg::TO3_CYC);
      3'h4: limit = 20'(TO4_CYC);
      3'h5: limit = 20'(TO5_CYC);
      3'h6: limit = 20'(TO6_CYC);
      default: limit = 20'(TO7_CYC);
    endcase
  end

  // cycles since the clock was last seen, saturating
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idle_q <= 20'h00000;
    end else if (port.clock_seen) begin
      idle_q <= 20'h00000;
    end else if (idle_q < limit) begin
      idle_q <= idle_q + 20'h00001;
    end
  end

  // shutdown policy holds the fault until the host recovers it
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      latched_q <= 1'b0;
    end else if (idle_q >= limit && port.shutdown_policy) begin
      latched_q <= 1'b1;
    end else if (port.host_recover) begin
      latched_q <= 1'b0;
    end
  end

  // automatic policy unmutes as soon as the clock returns
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mute_q <= 1'b0;
    end else begin
      mute_q <= (idle_q >= limit) || latched_q;
    end
  end

  assign port.mute = mute_q;
  assign port.latched = latched_q;
endmodule : clkfault_watchdog

// >>> logic/amp_clock_fault_config_regs.sv
`timescale 1ns/1ps
// configuration registers, clock fault watchdogs and transaction checksum
module amp_clock_fault_config_regs #(
  parameter int TO4_CYC = amp_cfg_pkg::TO4_CYC,
  parameter int TO5_CYC = amp_cfg_pkg::TO5_CYC,
  parameter int TO6_CYC = amp_cfg_pkg::TO6_CYC,
  parameter int TO7_CYC = amp_cfg_pkg::TO7_CYC
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // register port from the control bus front end
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_bus_byte_valid,
  input wire logic [7:0] i_bus_byte,
  output logic [7:0] o_rdata,
  output logic o_rdata_valid,
  // clock fault detector inputs
  input wire logic i_clk1_seen,
  input wire logic i_clk2_seen,
  input wire logic i_clk1_recover,
  input wire logic i_clk2_recover,
  // controls to the rest of the device
  output logic o_por_power_down,
  output logic [1:0] o_audio_serial_input_rate,
  output logic o_clkfault1_recovery_sel,
  output logic o_clkfault2_recovery_sel,
  output logic [1:0] o_clkfault_gain_ramp_rate,
  output logic [15:0] o_ramp_cycles_per_db,
  output logic o_overtemp_retry_disable,
  output logic o_playback_mute,
  output logic o_clkfault1_latched,
  output logic o_clkfault2_latched
);
  logic [7:0] low_power_q;
  logic [7:0] sample_rate_q;
  logic [7:0] clk_policy_q;
  logic [7:0] clk_timing_q;
  logic [7:0] prot_cfg_q;
  logic [7:0] checksum_q;
  logic [7:0] checksum_d;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [15:0] ramp_q;

  clkfault_if det1 ();
  clkfault_if det2 ();

  // plain storage, reserved bits kept as written
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      low_power_q <= amp_cfg_pkg::RST_LOW_POWER;
      sample_rate_q <= amp_cfg_pkg::RST_SAMPLE_RATE;
      clk_policy_q <= amp_cfg_pkg::RST_CLK_POLICY;
      clk_timing_q <= amp_cfg_pkg::RST_CLK_TIMING;
      prot_cfg_q <= amp_cfg_pkg::RST_PROT_CFG;
    end else if (i_wr_en) begin
      case (i_addr)
        amp_cfg_pkg::ADDR_LOW_POWER: low_power_q <= i_wdata;
        amp_cfg_pkg::ADDR_SAMPLE_RATE: sample_rate_q <= i_wdata;
        amp_cfg_pkg::ADDR_CLK_POLICY: clk_policy_q <= i_wdata;
        amp_cfg_pkg::ADDR_CLK_TIMING: clk_timing_q <= i_wdata;
        amp_cfg_pkg::ADDR_PROT_CFG: prot_cfg_q <= i_wdata;
        default: ;
      endcase
    end
  end

  // crc8 step over one byte, msb first
  function automatic logic [7:0] crc8_step(input logic [7:0] crc,
                                           input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ amp_cfg_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8_step

  // a write to the checksum register restarts from zero; the written
  // byte itself is not folded in, so the new interval starts clean
  always_comb begin
    checksum_d = checksum_q;
    if (i_wr_en && i_addr == amp_cfg_pkg::ADDR_CHECKSUM) begin
      checksum_d = amp_cfg_pkg::RST_CHECKSUM;
    end else if (i_bus_byte_valid) begin
      checksum_d = crc8_step(checksum_q, i_bus_byte);
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      checksum_q <= amp_cfg_pkg::RST_CHECKSUM;
    end else begin
      checksum_q <= checksum_d;
    end
  end

  // registered read data, unmapped addresses read zero
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= i_rd_en;
      if (i_rd_en) begin
        case (i_addr)
          amp_cfg_pkg::ADDR_LOW_POWER: rdata_q <= low_power_q;
          amp_cfg_pkg::ADDR_SAMPLE_RATE: rdata_q <= sample_rate_q;
          amp_cfg_pkg::ADDR_CLK_POLICY: rdata_q <= clk_policy_q;
          amp_cfg_pkg::ADDR_CLK_TIMING: rdata_q <= clk_timing_q;
          amp_cfg_pkg::ADDR_PROT_CFG: rdata_q <= prot_cfg_q;
          amp_cfg_pkg::ADDR_CHECKSUM: rdata_q <= checksum_q;
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // ramp rate to cycles per dB; undocumented code 2 takes the slowest
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ramp_q <= 16'(amp_cfg_pkg::RAMP_15_CYC);
    end else begin
      case (clk_timing_q[amp_cfg_pkg::POS_RAMP_LO +: 2])
        2'h0: ramp_q <= 16'(amp_cfg_pkg::RAMP_15_CYC);
        2'h1: ramp_q <= 16'(amp_cfg_pkg::RAMP_30_CYC);
        default: ramp_q <= 16'(amp_cfg_pkg::RAMP_60_CYC);
      endcase
    end
  end

  // detector hookup
  assign det1.timeout_code = clk_timing_q[amp_cfg_pkg::POS_TO1_LO +: 3];
  assign det1.shutdown_policy = clk_policy_q[amp_cfg_pkg::POS_CLK1_POLICY];
  assign det1.clock_seen = i_clk1_seen;
  assign det1.host_recover = i_clk1_recover;
  assign det2.timeout_code = clk_timing_q[amp_cfg_pkg::POS_TO2_LO +: 3];
  assign det2.shutdown_policy = clk_policy_q[amp_cfg_pkg::POS_CLK2_POLICY];
  assign det2.clock_seen = i_clk2_seen;
  assign det2.host_recover = i_clk2_recover;

  clkfault_watchdog #(
    .TO4_CYC(TO4_CYC),
    .TO5_CYC(TO5_CYC),
    .TO6_CYC(TO6_CYC),
    .TO7_CYC(TO7_CYC)
  ) u_det1 (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .port(det1)
  );

  clkfault_watchdog #(
    .TO4_CYC(TO4_CYC),
    .TO5_CYC(TO5_CYC),
    .TO6_CYC(TO6_CYC),
    .TO7_CYC(TO7_CYC)
  ) u_det2 (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .port(det2)
  );

  // outputs from the register bits, the registered ramp count and the detectors
  assign o_rdata = rdata_q;
  assign o_rdata_valid = rvalid_q;
  assign o_por_power_down = low_power_q[amp_cfg_pkg::POS_POR_OFF];
  assign o_audio_serial_input_rate =
    sample_rate_q[amp_cfg_pkg::POS_RATE_LO +: 2];
  assign o_clkfault1_recovery_sel =
    clk_policy_q[amp_cfg_pkg::POS_CLK1_POLICY];
  assign o_clkfault2_recovery_sel =
    clk_policy_q[amp_cfg_pkg::POS_CLK2_POLICY];
  assign o_clkfault_gain_ramp_rate =
    clk_timing_q[amp_cfg_pkg::POS_RAMP_LO +: 2];
  assign o_ramp_cycles_per_db = ramp_q;
  assign o_overtemp_retry_disable =
    prot_cfg_q[amp_cfg_pkg::POS_OT_RETRY_OFF];
  assign o_playback_mute = det1.mute | det2.mute;
  assign o_clkfault1_latched = det1.latched;
  assign o_clkfault2_latched = det2.latched;
endmodule : amp_clock_fault_config_regs

// >>> testbench/amp_cfg_assertions.sv
`timescale 1ns/1ps
// port-level rules of the register slice, attached by bind below
module amp_cfg_checker (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // register port
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_bus_byte_valid,
  input wire logic [7:0] o_rdata,
  input wire logic o_rdata_valid,
  // controls
  input wire logic o_por_power_down,
  input wire logic [1:0] o_audio_serial_input_rate,
  input wire logic o_clkfault1_recovery_sel,
  input wire logic o_clkfault2_recovery_sel,
  input wire logic [1:0] o_clkfault_gain_ramp_rate,
  input wire logic [15:0] o_ramp_cycles_per_db,
  input wire logic o_overtemp_retry_disable
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  // decoded write strobes, one per register, plus the checksum read strobe
  wire wr_lp = i_wr_en && i_addr == 7'h35;
  wire wr_rate = i_wr_en && i_addr == 7'h36;
  wire wr_pol = i_wr_en && i_addr == 7'h4F;
  wire wr_tim = i_wr_en && i_addr == 7'h50;
  wire wr_prot = i_wr_en && i_addr == 7'h58;
  wire wr_sum = i_wr_en && i_addr == 7'h7E;
  wire rd_sum = i_rd_en && i_addr == 7'h7E;
  sequence ramp_fast_wr;
    wr_tim && i_wdata[7:6] == 2'h0;
  endsequence
  // a bus byte between restart and read would legally move the sum
  sequence sum_clear_rd;
    (wr_sum ##1 rd_sum) or (wr_sum ##1 !i_bus_byte_valid ##1 rd_sum);
  endsequence
  read_answer_a: assert property (i_rd_en |=> o_rdata_valid)
    else $error("read not answered");
  por_ctrl_a: assert property (wr_lp |=>
    o_por_power_down == $past(i_wdata[7])) else $error("por bit wrong");
  rate_sel_a: assert property (wr_rate |=>
    o_audio_serial_input_rate == $past(i_wdata[1:0]))
    else $error("rate wrong");
  det2_policy_a: assert property (wr_pol |=>
    o_clkfault2_recovery_sel == $past(i_wdata[3]))
    else $error("policy 2 wrong");
  det1_policy_a: assert property (wr_pol |=>
    o_clkfault1_recovery_sel == $past(i_wdata[2]))
    else $error("policy 1 wrong");
  ramp_rate_a: assert property (ramp_fast_wr |=>
    o_clkfault_gain_ramp_rate == 2'h0 ##1 o_ramp_cycles_per_db == 16'h0BB8)
    else $error("ramp rate wrong");
  overtemp_retry_a: assert property (wr_prot |=>
    o_overtemp_retry_disable == $past(i_wdata[2]))
    else $error("retry bit wrong");
  sum_restart_a: assert property (sum_clear_rd |=>
    o_rdata == 8'h00) else $error("checksum not cleared");
endmodule : amp_cfg_checker

bind amp_clock_fault_config_regs amp_cfg_checker chk (.*);

// >>> testbench/host_bus_model.sv
`timescale 1ns/1ps
// host side of the register port; requests launched 1 ns after an edge
module host_bus_model (
  // clock and answers
  input wire logic i_clock,
  input wire logic [7:0] i_rdata,
  input wire logic i_rdata_valid,
  // requests
  output logic o_wr_en = 1'b0,
  output logic o_rd_en = 1'b0,
  output logic [6:0] o_addr = 7'h00,
  output logic [7:0] o_wdata = 8'h00,
  output logic o_bv = 1'b0,
  output logic [7:0] o_byte = 8'h00
);
  // released lines show the inverse so stale values are never trusted
  task automatic write(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clock);
    #1 {o_wr_en, o_addr, o_wdata} = {1'b1, a, d};
    @(posedge i_clock);
    #1 {o_wr_en, o_addr, o_wdata} = {1'b0, ~a, ~d};
  endtask : write
  task automatic read(input logic [6:0] a, output logic [7:0] d);
    @(posedge i_clock);
    #1 {o_rd_en, o_addr} = {1'b1, a};
    @(posedge i_clock);
    #1 {o_rd_en, o_addr} = {1'b0, ~a};
    d = i_rdata_valid === 1'b1 ? i_rdata : 8'hXX;
  endtask : read
  task automatic send(input logic [7:0] b);
    @(posedge i_clock);
    #1 {o_bv, o_byte} = {1'b1, b};
    @(posedge i_clock);
    #1 {o_bv, o_byte} = {1'b0, ~b};
  endtask : send
endmodule : host_bus_model

// >>> testbench/amp_clock_fault_config_regs_test.sv
`timescale 1ns/1ps
module amp_clock_fault_config_regs_test;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] seen = 2'h3;
  logic [1:0] rec = 2'h0;
  wire wr_en, rd_en, bv, rdv, por, sel1, sel2, otd, mute, lat1, lat2;
  wire [6:0] addr;
  wire [7:0] wdata, bbyte, rdata;
  wire [1:0] rate, ramp;
  wire [15:0] rcyc;
  int miscompares = 0;
  int n_tests = 0;
  logic [6:0] regs[6] = '{7'h35, 7'h36, 7'h4F, 7'h50, 7'h58, 7'h7E};
  logic [7:0] rsts[6] = '{8'h00, 8'h32, 8'h00, 8'h11, 8'h03, 8'h00};
  always #2.5 clock = ~clock;
  // long timeouts shortened, still above the code 0 count
  amp_clock_fault_config_regs #(.TO4_CYC(5000), .TO5_CYC(6000),
    .TO6_CYC(7000), .TO7_CYC(8000)) DUT (.i_clock(clock),
    .i_arst_n(arst_n), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
    .i_wdata(wdata), .i_bus_byte_valid(bv), .i_bus_byte(bbyte),
    .o_rdata(rdata), .o_rdata_valid(rdv), .i_clk1_seen(seen[0]),
    .i_clk2_seen(seen[1]), .i_clk1_recover(rec[0]),
    .i_clk2_recover(rec[1]), .o_por_power_down(por),
    .o_audio_serial_input_rate(rate), .o_clkfault1_recovery_sel(sel1),
    .o_clkfault2_recovery_sel(sel2), .o_clkfault_gain_ramp_rate(ramp),
    .o_ramp_cycles_per_db(rcyc), .o_overtemp_retry_disable(otd),
    .o_playback_mute(mute), .o_clkfault1_latched(lat1),
    .o_clkfault2_latched(lat2));
  host_bus_model host (.i_clock(clock), .i_rdata(rdata),
    .i_rdata_valid(rdv), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
    .o_wdata(wdata), .o_bv(bv), .o_byte(bbyte));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // msb-first crc, polynomial 0x07, no final inversion
  function automatic logic [7:0] crc_step(logic [7:0] c, logic [7:0] b);
    c ^= b;
    repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction : crc_step
  task automatic t_reset;
    logic [7:0] d;
    foreach (regs[i]) begin
      host.read(regs[i], d);
      chk(d, rsts[i]);
    end
    chk({rate, ramp}, 4'h8);
  endtask : t_reset
  // 00/55/AA/FF walk every rate and ramp code through all fields
  task automatic t_fields;
    logic [7:0] d, q;
    for (int k = 0; k < 4; k++) begin
      d = 8'(k * 8'h55);
      for (int i = 0; i < 5; i++) host.write(regs[i], d);
      tick(2);
      for (int i = 0; i < 5; i++) begin
        host.read(regs[i], q);
        chk(q, d);
      end
      chk(por, d[7]);
      chk(rate, d[1:0]);
      chk({sel2, sel1}, d[3:2]);
      chk(ramp, d[7:6]);
      chk(rcyc, k == 0 ? 16'h0BB8 : k == 1 ? 16'h1770 : 16'h2EE0);
      chk(otd, d[2]);
    end
    host.write(7'h37, 8'h5A);
    host.read(7'h37, q);
    chk(q, 8'h00);
    host.read(7'h35, q);
    chk(q, 8'hFF);
  endtask : t_fields
  task automatic t_crc;
    logic [7:0] q, c;
    host.write(7'h7E, 8'hA5);
    host.read(7'h7E, q);
    chk(q, 8'h00);
    c = 8'h00;
    foreach (rsts[i]) begin
      host.send(rsts[i] ^ 8'hC3);
      c = crc_step(c, rsts[i] ^ 8'hC3);
    end
    host.read(7'h7E, q);
    chk(q, c);
    host.write(7'h7E, 8'h00);
    host.read(7'h7E, q);
    chk(q, 8'h00);
  endtask : t_crc
  // other detector gets code 7, so a swapped field shows as a late mute
  task automatic t_det(input int i, input logic pol);
    host.write(7'h50, i ? 8'h38 : 8'h07);
    host.write(7'h4F, pol ? (i ? 8'h08 : 8'h04) : 8'h00);
    seen[i] = 1'b0;
    tick(2100);
    chk(mute, 1'b0);
    for (int n = 0; n < 60 && mute !== 1'b1; n++) tick(1);
    chk(mute, 1'b1);
    seen[i] = 1'b1;
    tick(10);
    chk({mute, i ? lat2 : lat1}, {2{pol}});
    rec[i] = 1'b1;
    tick(1);
    rec[i] = 1'b0;
    tick(4);
    chk({mute, lat2, lat1}, 3'h0);
  endtask : t_det
  task automatic print_verdict;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // about 6500 cycles expected, hang cut at 40000
  initial begin
    #(5 * 40000);
    miscompares++;
    print_verdict();
  end
  initial begin
    tick(3);
    arst_n = 1'b1;
    t_reset();
    t_fields();
    t_crc();
    t_det(0, 1'b0);
    t_det(0, 1'b1);
    t_det(1, 1'b1);
    print_verdict();
  end
endmodule : amp_clock_fault_config_regs_test
